// [hw/port_b_d_alt_function_mux.sv]
`timescale 1ns/10ps
module port_b_d_alt_function_mux
  import pin_mux_pkg::*;
(
  // clock and reset
  input  wire logic      clk_sys,
  input  wire logic      rst_n,
  // port b registers
  input  wire port_vec_t portb_dir,
  input  wire port_vec_t portb_data,
  input  wire port_vec_t portb_digital_in_off,
  // port d registers
  input  wire port_vec_t portd_dir,
  input  wire port_vec_t portd_data,
  input  wire port_vec_t portd_digital_in_off,
  // global control
  input  wire logic      global_pullup_disable,
  // spi
  input  wire logic      spi_enable,
  input  wire logic      spi_master,
  input  wire logic      spi_sck_out,
  input  wire logic      spi_mosi_out,
  // power stage controller outputs and selects
  input  wire logic      stage2_output_0,
  input  wire logic      stage2_output_1,
  input  wire logic      stage2_output_3,
  input  wire logic      stage2_out0_en,
  input  wire logic      stage2_out1_en,
  input  wire logic      stage2_out3_en,
  input  wire logic      reduced_stage_output_0,
  input  wire logic      reduced_stage_output_1,
  input  wire logic      reduced_out0_en,
  input  wire logic      reduced_out1_en,
  // comparator outputs and selects
  input  wire logic      comparator3_output,
  input  wire logic      comparator3_out_en,
  input  wire logic      comparator2_output,
  input  wire logic      comparator2_out_en,
  // pad inputs
  input  wire port_vec_t portb_pad_in,
  input  wire port_vec_t portd_pad_in,
  // port b pad controls
  output port_vec_t      portb_pad_out,
  output port_vec_t      portb_pad_oe_n,
  output port_vec_t      portb_pullup_en,
  output port_vec_t      portb_pin_value,
  // port d pad controls
  output port_vec_t      portd_pad_out,
  output port_vec_t      portd_pad_oe_n,
  output port_vec_t      portd_pullup_en,
  output port_vec_t      portd_pin_value,
  // digital inputs to peripherals
  output logic           ext_irq_source_1,
  output logic           ext_irq_source_0,
  output logic           timer_count_source,
  output logic           spi_sck_in,
  output logic           spi_mosi_in,
  output logic           reduced_stage_alt_input_a,
  output logic           reduced_stage_alt_input_b,
  output logic           stage2_alt_input
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  state_t    state_reg;
  state_t    state_next;

  port_vec_t b_out;
  port_vec_t b_oe_n;
  port_vec_t b_pu;
  port_vec_t d_out;
  port_vec_t d_oe_n;
  port_vec_t d_pu;

  logic      sck_ddoe;
  logic      sck_ddov;
  logic      sck_pvoe;
  logic      sck_pvov;
  logic      mosi_ddoe;
  logic      mosi_ddov;
  logic      mosi_pvoe;
  logic      mosi_pvov;

  override_if ovr_b ();
  override_if ovr_d ();

  ////////////////////////////////////////////////////////////////////////////
  // spi direction and value overrides

  spi_pin_override u_spi (
    .spi_enable   (spi_enable),
    .spi_master   (spi_master),
    .spi_sck_out  (spi_sck_out),
    .spi_mosi_out (spi_mosi_out),
    .sck_ddoe     (sck_ddoe),
    .sck_ddov     (sck_ddov),
    .sck_pvoe     (sck_pvoe),
    .sck_pvov     (sck_pvov),
    .mosi_ddoe    (mosi_ddoe),
    .mosi_ddov    (mosi_ddov),
    .mosi_pvoe    (mosi_pvoe),
    .mosi_pvov    (mosi_pvov)
  );

  ////////////////////////////////////////////////////////////////////////////
  // port b overrides

  always_comb begin
    ovr_b.ddoe = '0;
    ovr_b.ddov = '0;
    ovr_b.pvoe = '0;
    ovr_b.pvov = '0;
    ovr_b.ddoe[PB_SCK]  = sck_ddoe;
    ovr_b.ddov[PB_SCK]  = sck_ddov;
    ovr_b.pvoe[PB_SCK]  = sck_pvoe;
    ovr_b.pvov[PB_SCK]  = sck_pvov;
    ovr_b.ddoe[PB_MOSI] = mosi_ddoe;
    ovr_b.ddov[PB_MOSI] = mosi_ddov;
    ovr_b.pvoe[PB_MOSI] = mosi_pvoe;
    ovr_b.pvov[PB_MOSI] = mosi_pvov;
    // selected peripheral outputs take over both drive and value
    ovr_b.ddoe[PB_RS1]  = reduced_out1_en;
    ovr_b.ddov[PB_RS1]  = reduced_out1_en;
    ovr_b.pvoe[PB_RS1]  = reduced_out1_en;
    ovr_b.pvov[PB_RS1]  = reduced_stage_output_1;
    ovr_b.ddoe[PB_IRQ0] = stage2_out1_en;
    ovr_b.ddov[PB_IRQ0] = stage2_out1_en;
    ovr_b.pvoe[PB_IRQ0] = stage2_out1_en;
    ovr_b.pvov[PB_IRQ0] = stage2_output_1;
    ovr_b.ddoe[PB_S2O0] = stage2_out0_en;
    ovr_b.ddov[PB_S2O0] = stage2_out0_en;
    ovr_b.pvoe[PB_S2O0] = stage2_out0_en;
    ovr_b.pvov[PB_S2O0] = stage2_output_0;
    // stage2 output 3 has priority over comparator 3
    ovr_b.ddoe[PB_TMR]  = stage2_out3_en | comparator3_out_en;
    ovr_b.ddov[PB_TMR]  = stage2_out3_en | comparator3_out_en;
    ovr_b.pvoe[PB_TMR]  = stage2_out3_en | comparator3_out_en;
    ovr_b.pvov[PB_TMR]  = stage2_out3_en ? stage2_output_3 : comparator3_output;
  end

  ////////////////////////////////////////////////////////////////////////////
  // port d overrides

  always_comb begin
    ovr_d.ddoe = '0;
    ovr_d.ddov = '0;
    ovr_d.pvoe = '0;
    ovr_d.pvov = '0;
    ovr_d.ddoe[PD_RS0]  = reduced_out0_en;
    ovr_d.ddov[PD_RS0]  = reduced_out0_en;
    ovr_d.pvoe[PD_RS0]  = reduced_out0_en;
    ovr_d.pvov[PD_RS0]  = reduced_stage_output_0;
    ovr_d.ddoe[PD_CMP2] = comparator2_out_en;
    ovr_d.ddov[PD_CMP2] = comparator2_out_en;
    ovr_d.pvoe[PD_CMP2] = comparator2_out_en;
    ovr_d.pvov[PD_CMP2] = comparator2_output;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad resolution

  port_override_resolve u_res_b (
    .dir        (portb_dir),
    .data       (portb_data),
    .pullup_off (global_pullup_disable),
    .ovr        (ovr_b.dst),
    .pad_out    (b_out),
    .pad_oe_n   (b_oe_n),
    .pullup_en  (b_pu)
  );

  port_override_resolve u_res_d (
    .dir        (portd_dir),
    .data       (portd_data),
    .pullup_off (global_pullup_disable),
    .ovr        (ovr_d.dst),
    .pad_out    (d_out),
    .pad_oe_n   (d_oe_n),
    .pullup_en  (d_pu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registered state

  always_comb begin
    state_next         = state_reg;
    state_next.pb_out  = b_out;
    state_next.pb_oe_n = b_oe_n;
    state_next.pb_pu   = b_pu;
    state_next.pd_out  = d_out;
    state_next.pd_oe_n = d_oe_n;
    state_next.pd_pu   = d_pu;
    // analog-shared pins can have their digital input switched off
    state_next.pb_pin  = portb_pad_in & ~portb_digital_in_off;
    state_next.pd_pin  = portd_pad_in & ~portd_digital_in_off;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.pb_out  <= RST_PAD_OUT;
      state_reg.pb_oe_n <= RST_OE_N;
      state_reg.pb_pu   <= RST_PULLUP;
      state_reg.pb_pin  <= RST_PIN;
      state_reg.pd_out  <= RST_PAD_OUT;
      state_reg.pd_oe_n <= RST_OE_N;
      state_reg.pd_pu   <= RST_PULLUP;
      state_reg.pd_pin  <= RST_PIN;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign portb_pad_out             = state_reg.pb_out;
  assign portb_pad_oe_n            = state_reg.pb_oe_n;
  assign portb_pullup_en           = state_reg.pb_pu;
  assign portb_pin_value           = state_reg.pb_pin;
  assign portd_pad_out             = state_reg.pd_out;
  assign portd_pad_oe_n            = state_reg.pd_oe_n;
  assign portd_pullup_en           = state_reg.pd_pu;
  assign portd_pin_value           = state_reg.pd_pin;
  assign ext_irq_source_1          = state_reg.pb_pin[PB_SCK];
  assign ext_irq_source_0          = state_reg.pb_pin[PB_IRQ0];
  assign timer_count_source        = state_reg.pb_pin[PB_TMR];
  assign spi_sck_in                = state_reg.pb_pin[PB_SCK];
  assign spi_mosi_in               = state_reg.pb_pin[PB_MOSI];
  assign reduced_stage_alt_input_a = state_reg.pd_pin[PD_RSA];
  assign reduced_stage_alt_input_b = state_reg.pd_pin[PD_RS0];
  assign stage2_alt_input          = state_reg.pd_pin[PD_S2IN];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence spi_slave_s;
    spi_enable && !spi_master;
  endsequence

  sequence spi_master_s;
    spi_enable && spi_master;
  endsequence

  sequence slave_released_s;
    spi_slave_s ##1 !spi_enable;
  endsequence

  sck_slave_input_a : assert property (spi_slave_s |=> portb_pad_oe_n[PB_SCK])
    else $error("clock pin driven while spi slave");

  sck_master_dir_a : assert property (spi_master_s |=> portb_pad_oe_n[PB_SCK] == !$past(portb_dir[PB_SCK]))
    else $error("clock pin direction ignores direction bit as master");

  sck_slave_pullup_a : assert property (spi_slave_s |=>
      portb_pullup_en[PB_SCK] == ($past(portb_data[PB_SCK]) && !$past(global_pullup_disable)))
    else $error("clock pin pull-up wrong while forced input");

  mosi_slave_input_a : assert property (spi_slave_s |=> portb_pad_oe_n[PB_MOSI])
    else $error("mosi pin driven while spi slave");

  mosi_slave_pullup_a : assert property (spi_slave_s |=>
      portb_pullup_en[PB_MOSI] == ($past(portb_data[PB_MOSI]) && !$past(global_pullup_disable)))
    else $error("mosi pin pull-up wrong while forced input");

  slave_release_a : assert property (slave_released_s |=>
      portb_pad_oe_n[PB_MOSI] == !$past(portb_dir[PB_MOSI]))
    else $error("mosi pin direction not restored after spi off");

  pullup_global_off_a : assert property (global_pullup_disable |=>
      (portb_pullup_en == '0) && (portd_pullup_en == '0))
    else $error("pull-up on while globally disabled");

  irq1_input_a : assert property (1'b1 |=>
      ext_irq_source_1 == ($past(portb_pad_in[PB_SCK]) && !$past(portb_digital_in_off[PB_SCK])))
    else $error("interrupt source 1 not from port b bit 5");

  stage2_out1_a : assert property (stage2_out1_en |=>
      !portb_pad_oe_n[PB_IRQ0] && portb_pad_out[PB_IRQ0] == $past(stage2_output_1))
    else $error("stage2 output 1 not on port b bit 2");

  stage2_out0_a : assert property (stage2_out0_en |=>
      !portb_pad_oe_n[PB_S2O0] && portb_pad_out[PB_S2O0] == $past(stage2_output_0))
    else $error("stage2 output 0 not on port b bit 1");

  timer_pin_mux_a : assert property (!stage2_out3_en && comparator3_out_en |=>
      !portb_pad_oe_n[PB_TMR] && portb_pad_out[PB_TMR] == $past(comparator3_output))
    else $error("comparator 3 output not on port b bit 0");

  reduced_out0_a : assert property (reduced_out0_en |=>
      !portd_pad_oe_n[PD_RS0] && portd_pad_out[PD_RS0] == $past(reduced_stage_output_0))
    else $error("reduced stage output 0 not on port d bit 1");

  plain_pin_a : assert property (1'b1 |=>
      portd_pad_oe_n[6] == !$past(portd_dir[6]) && portd_pad_out[6] == $past(portd_data[6]))
    else $error("plain port d bit 6 not following port bits");

endmodule : port_b_d_alt_function_mux

// [hw/pin_mux_pkg.sv]
// Notes on behaviour
// - SPI slave forces clock pin input; as master its direction bit rules.
// - Forced-input clock pin keeps its pull-up steered by its port data bit.
// - SPI slave forces MOSI pin input; as master its direction bit rules.
// - Forced-input MOSI pin pull-up follows its data bit and global disable.
// - Port B bit 5 input feeds external interrupt source 1.
// - Port B bit 2 feeds interrupt source 0 and can drive stage2 output 1.
// - Port B bit 1 carries stage2 output 0 when that output is selected.
// - Port B bit 0 feeds timer count; carries stage2 output 3 or comparator 3.
// - Port B bit 3 carries reduced stage output 1; shared with analog inputs.
// - Port D bit 1 carries reduced stage output 0 and feeds its input b.
// - Port D bit 7 feeds reduced stage input a; shared with analog channel.
// - Port D bit 4 feeds stage2 alternate input; shared with analog inputs.
// - Port D bit 3 can carry comparator 2 output; shared with analog input.
// - Global pull-up disable turns every port pull-up off.
package pin_mux_pkg;

  localparam int unsigned PORT_W = 8;

  // port b pin positions
  localparam int unsigned PB_SCK  = 5;
  localparam int unsigned PB_MOSI = 4;
  localparam int unsigned PB_RS1  = 3;
  localparam int unsigned PB_IRQ0 = 2;
  localparam int unsigned PB_S2O0 = 1;
  localparam int unsigned PB_TMR  = 0;

  // port d pin positions
  localparam int unsigned PD_RSA  = 7;
  localparam int unsigned PD_S2IN = 4;
  localparam int unsigned PD_CMP2 = 3;
  localparam int unsigned PD_RS0  = 1;

  // reset values
  localparam logic [PORT_W-1:0] RST_PAD_OUT = 8'h00;
  localparam logic [PORT_W-1:0] RST_OE_N    = 8'hff;
  localparam logic [PORT_W-1:0] RST_PULLUP  = 8'h00;
  localparam logic [PORT_W-1:0] RST_PIN     = 8'h00;
  localparam logic              RST_BIT     = 1'b0;

  typedef logic [PORT_W-1:0] port_vec_t;

  typedef struct packed {
    port_vec_t pb_out;
    port_vec_t pb_oe_n;
    port_vec_t pb_pu;
    port_vec_t pb_pin;
    port_vec_t pd_out;
    port_vec_t pd_oe_n;
    port_vec_t pd_pu;
    port_vec_t pd_pin;
  } state_t;

endpackage : pin_mux_pkg

// [hw/override_if.sv]
`timescale 1ns/10ps
interface override_if
  import pin_mux_pkg::*;
;
  port_vec_t ddoe;
  port_vec_t ddov;
  port_vec_t pvoe;
  port_vec_t pvov;

  modport src (output ddoe, ddov, pvoe, pvov);
  modport dst (input  ddoe, ddov, pvoe, pvov);
endinterface : override_if

// [hw/spi_pin_override.sv]
`timescale 1ns/10ps
module spi_pin_override (
  // spi mode
  input  wire logic spi_enable,
  input  wire logic spi_master,
  // master drive values
  input  wire logic spi_sck_out,
  input  wire logic spi_mosi_out,
  // clock pin override
  output logic      sck_ddoe,
  output logic      sck_ddov,
  output logic      sck_pvoe,
  output logic      sck_pvov,
  // mosi pin override
  output logic      mosi_ddoe,
  output logic      mosi_ddov,
  output logic      mosi_pvoe,
  output logic      mosi_pvov
);

  logic slave_on;
  logic master_on;

  always_comb begin
    slave_on  = spi_enable & ~spi_master;
    master_on = spi_enable & spi_master;
    // slave: direction forced to input; master: direction bit kept
    sck_ddoe  = slave_on;
    sck_ddov  = 1'b0;
    mosi_ddoe = slave_on;
    mosi_ddov = 1'b0;
    // master drives its own clock and data when the pin is an output
    sck_pvoe  = master_on;
    sck_pvov  = spi_sck_out;
    mosi_pvoe = master_on;
    mosi_pvov = spi_mosi_out;
  end

endmodule : spi_pin_override

// [hw/port_override_resolve.sv]
`timescale 1ns/10ps
module port_override_resolve
  import pin_mux_pkg::*;
(
  // port register bits
  input  wire port_vec_t dir,
  input  wire port_vec_t data,
  input  wire logic      pullup_off,
  // alternate function overrides
  override_if.dst        ovr,
  // resolved pad controls
  output port_vec_t      pad_out,
  output port_vec_t      pad_oe_n,
  output port_vec_t      pullup_en
);

  port_vec_t drive;

  always_comb begin
    drive    = (ovr.ddoe & ovr.ddov) | (~ovr.ddoe & dir);
    pad_out  = (ovr.pvoe & ovr.pvov) | (~ovr.pvoe & data);
    pad_oe_n = ~drive;
    // an input pin keeps its data-bit pull-up, global disable wins
    pullup_en = ~drive & data & {PORT_W{~pullup_off}};
  end

endmodule : port_override_resolve

// [verification/periph_model.sv]
`timescale 1ns/10ps
module periph_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // behaviour select
  input  wire logic [8:0] hold_value,
  input  wire logic       fast,
  // spi, power stage and comparator output values
  output logic [8:0]      periph_out
);
  // a fast peripheral changes its outputs every cycle, so a stale capture shows
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      periph_out <= 9'h000;
    end else if (fast) begin
      periph_out <= periph_out + 9'h0ab;
    end else begin
      periph_out <= hold_value;
    end
  end
endmodule : periph_model

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import pin_mux_pkg::*;
  typedef struct packed {
    port_vec_t  bd, bv, boff, bin, dd, dv, doff, din;
    logic       pu_off, en, ms;
    logic [8:0] pv;
    logic [6:0] sel;
  } snap_t;
  logic       clk_sys = 1'b0;
  logic       rst_n;
  port_vec_t  portb_dir, portb_data, portb_digital_in_off, portb_pad_in;
  port_vec_t  portd_dir, portd_data, portd_digital_in_off, portd_pad_in;
  logic       global_pullup_disable, spi_enable, spi_master, fast;
  logic [6:0] sel;
  logic [8:0] hold_value, pv;
  port_vec_t  portb_pad_out, portb_pad_oe_n, portb_pullup_en, portb_pin_value;
  port_vec_t  portd_pad_out, portd_pad_oe_n, portd_pullup_en, portd_pin_value;
  wire  [7:0] periph_in;
  snap_t      snap;
  int         fails, comparisons, cycles;
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  periph_model partner (.clk_sys(clk_sys), .rst_n(rst_n), .hold_value(hold_value), .fast(fast), .periph_out(pv));
  port_b_d_alt_function_mux dut (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .portb_dir(portb_dir), .portb_data(portb_data), .portb_digital_in_off(portb_digital_in_off),
    .portd_dir(portd_dir), .portd_data(portd_data), .portd_digital_in_off(portd_digital_in_off),
    .global_pullup_disable(global_pullup_disable), .spi_enable(spi_enable), .spi_master(spi_master),
    .spi_sck_out(pv[8]), .spi_mosi_out(pv[7]), .stage2_output_0(pv[6]), .stage2_output_1(pv[5]),
    .stage2_output_3(pv[4]), .reduced_stage_output_0(pv[3]), .reduced_stage_output_1(pv[2]),
    .comparator3_output(pv[1]), .comparator2_output(pv[0]),
    .stage2_out0_en(sel[6]), .stage2_out1_en(sel[5]), .stage2_out3_en(sel[4]), .reduced_out0_en(sel[3]),
    .reduced_out1_en(sel[2]), .comparator3_out_en(sel[1]), .comparator2_out_en(sel[0]),
    .portb_pad_in(portb_pad_in), .portd_pad_in(portd_pad_in),
    .portb_pad_out(portb_pad_out), .portb_pad_oe_n(portb_pad_oe_n), .portb_pullup_en(portb_pullup_en),
    .portb_pin_value(portb_pin_value), .portd_pad_out(portd_pad_out), .portd_pad_oe_n(portd_pad_oe_n),
    .portd_pullup_en(portd_pullup_en), .portd_pin_value(portd_pin_value),
    .ext_irq_source_1(periph_in[7]), .ext_irq_source_0(periph_in[6]), .timer_count_source(periph_in[5]),
    .spi_sck_in(periph_in[4]), .spi_mosi_in(periph_in[3]), .reduced_stage_alt_input_a(periph_in[2]),
    .reduced_stage_alt_input_b(periph_in[1]), .stage2_alt_input(periph_in[0])
  );
  // inputs as the design sampled them at the latest edge
  always @(posedge clk_sys) begin
    snap <= {portb_dir, portb_data, portb_digital_in_off, portb_pad_in, portd_dir, portd_data,
             portd_digital_in_off, portd_pad_in, global_pullup_disable, spi_enable, spi_master, pv, sel};
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp(input string name, input port_vec_t exp, input port_vec_t got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  task automatic chk_reset();
    cmp("portb_pad_oe_n", RST_OE_N, portb_pad_oe_n);
    cmp("portd_pad_oe_n", RST_OE_N, portd_pad_oe_n);
    cmp("portb_pad_out", RST_PAD_OUT, portb_pad_out);
    cmp("portd_pullup_en", RST_PULLUP, portd_pullup_en);
    cmp("portb_pin_value", RST_PIN, portb_pin_value);
    cmp("peripheral_inputs", 8'h00, periph_in);
  endtask : chk_reset
  // expected pad controls worked out from the sampled inputs
  task automatic chk();
    port_vec_t bdrv, bo, ddrv, dout, bpin, dpin;
    bdrv = snap.bd;
    bo   = snap.bv;
    ddrv = snap.dd;
    dout = snap.dv;
    if (snap.en && !snap.ms) begin
      bdrv[5] = 1'b0;
      bdrv[4] = 1'b0;
    end
    if (snap.en && snap.ms) begin
      bo[5] = snap.pv[8];
      bo[4] = snap.pv[7];
    end
    if (snap.sel[6]) {bdrv[1], bo[1]} = {1'b1, snap.pv[6]};
    if (snap.sel[5]) {bdrv[2], bo[2]} = {1'b1, snap.pv[5]};
    if (snap.sel[4]) {bdrv[0], bo[0]} = {1'b1, snap.pv[4]};
    else if (snap.sel[1]) {bdrv[0], bo[0]} = {1'b1, snap.pv[1]};
    if (snap.sel[3]) {ddrv[1], dout[1]} = {1'b1, snap.pv[3]};
    if (snap.sel[2]) {bdrv[3], bo[3]} = {1'b1, snap.pv[2]};
    if (snap.sel[0]) {ddrv[3], dout[3]} = {1'b1, snap.pv[0]};
    bpin = snap.bin & ~snap.boff;
    dpin = snap.din & ~snap.doff;
    cmp("portb_pad_oe_n", ~bdrv, portb_pad_oe_n);
    cmp("portd_pad_oe_n", ~ddrv, portd_pad_oe_n);
    cmp("portb_pad_out", bo & bdrv, portb_pad_out & bdrv);
    cmp("portd_pad_out", dout & ddrv, portd_pad_out & ddrv);
    cmp("portb_pullup_en", ~bdrv & snap.bv & {8{~snap.pu_off}}, portb_pullup_en);
    cmp("portd_pullup_en", ~ddrv & snap.dv & {8{~snap.pu_off}}, portd_pullup_en);
    cmp("portb_pin_value", bpin, portb_pin_value);
    cmp("portd_pin_value", dpin, portd_pin_value);
    cmp("peripheral_inputs", {bpin[5], bpin[2], bpin[0], bpin[5], bpin[4], dpin[7], dpin[1], dpin[4]},
        periph_in);
  endtask : chk
  task automatic go(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      chk();
    end
  endtask : go
  task automatic mode(input logic en, input logic ms, input logic [6:0] s, input logic f, input logic [8:0] h);
    @(posedge clk_sys);
    spi_enable <= en;
    spi_master <= ms;
    sel        <= s;
    fast       <= f;
    hold_value <= h;
  endtask : mode
  task automatic step(input port_vec_t bd, bv, dd, dv, input logic pu_off, input int n);
    @(posedge clk_sys);
    portb_dir             <= bd;
    portb_data            <= bv;
    portd_dir             <= dd;
    portd_data            <= dv;
    global_pullup_disable <= pu_off;
    go(n);
  endtask : step
  task automatic pads(input port_vec_t bin, din, boff, doff);
    @(posedge clk_sys);
    portb_pad_in         <= bin;
    portd_pad_in         <= din;
    portb_digital_in_off <= boff;
    portd_digital_in_off <= doff;
    go(2);
  endtask : pads
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    {rst_n, portb_dir, portb_data, portb_digital_in_off, portb_pad_in} = '0;
    {portd_dir, portd_data, portd_digital_in_off, portd_pad_in, global_pullup_disable} = '0;
    {spi_enable, spi_master, fast, sel, hold_value, fails, comparisons, cycles} = '0;
    repeat (5) @(posedge clk_sys);
    #1;
    chk_reset();
    @(posedge clk_sys);
    rst_n <= 1'b1;
    step(8'h0f, 8'h3c, 8'hf0, 8'h5a, 1'b0, 2);
    step(8'h0f, 8'h3c, 8'hf0, 8'h5a, 1'b1, 2);
    step(8'h00, 8'hff, 8'h00, 8'hff, 1'b1, 2);
    step(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 2);
    mode(1'b1, 1'b0, 7'h00, 1'b1, 9'h000);
    step(8'hff, 8'hff, 8'hff, 8'hff, 1'b0, 3);
    step(8'h30, 8'h30, 8'h00, 8'h00, 1'b0, 2);
    step(8'h30, 8'h30, 8'h00, 8'h00, 1'b1, 2);
    // slave switched off: direction bits take the clock and mosi pins back
    mode(1'b0, 1'b0, 7'h00, 1'b1, 9'h000);
    step(8'h30, 8'h30, 8'h00, 8'h00, 1'b0, 2);
    mode(1'b1, 1'b1, 7'h00, 1'b1, 9'h000);
    step(8'h30, 8'h00, 8'h00, 8'h00, 1'b0, 4);
    step(8'h10, 8'h20, 8'h00, 8'h00, 1'b0, 2);
    for (int i = 0; i < 7; i++) begin
      mode(1'b0, 1'b0, 7'h01 << i, 1'b1, 9'h000);
      step(8'h00, 8'hff, 8'h00, 8'hff, 1'b0, 3);
    end
    mode(1'b0, 1'b0, 7'h12, 1'b1, 9'h000);
    step(8'hff, 8'h00, 8'hff, 8'h00, 1'b0, 3);
    mode(1'b0, 1'b0, 7'h7f, 1'b0, 9'h1ff);
    step(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 2);
    mode(1'b0, 1'b0, 7'h00, 1'b0, 9'h000);
    for (int i = 0; i < 8; i++) begin
      pads(8'h01 << i, 8'h80 >> i, 8'h00, 8'h00);
    end
    pads(8'hff, 8'hff, 8'h08, 8'h98);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk_reset();
    @(posedge clk_sys);
    rst_n <= 1'b1;
    go(2);
    give_verdict();
  end
endmodule : tb_top
